// *** tb/amd_decoder_checker.sv ***
// concurrent checks on the addressing-mode decoder ports
// assumes one clock domain with synchronous active-low reset
`timescale 1ns/10ps
module amd_decoder_checker #(
   parameter int IDX_W = 8
) (
   input logic CLOCK_I,
   input logic RST_N_I,
   input logic OP_VALID_I,
   input logic [7:0] OPCODE_I,
   input logic [IDX_W-1:0] X_I,
   input logic BUSY_O,
   input logic WAIT_O,
   input logic HALT_O,
   input logic PTR_RD_O,
   input logic [15:0] PTR_ADDR_O,
   input logic DONE_O,
   input amd_pkg::amd_mode_t MODE_O,
   input logic [2:0] LEN_O,
   input logic [15:0] EA_O,
   input logic ILLEGAL_O,
   input logic RMW_O,
   input logic [1:0] IRQ_MASK_O
);
   import amd_pkg::*;
   logic take;
   assign take = OP_VALID_I && !BUSY_O && !WAIT_O && !HALT_O;
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);
   property p_inh_len;
      take && OPCODE_I[7:3] == 5'h00 |-> ##2 DONE_O && LEN_O == 3'h1;
   endproperty
   a_inh_len: assert property (p_inh_len) else $error("inherent length wrong");
   property p_len;
      DONE_O && (MODE_O == AMD_M_IMM || MODE_O == AMD_M_LDIR)
         |-> LEN_O == ((MODE_O == AMD_M_IMM) ? 3'h2 : 3'h3);
   endproperty
   a_len: assert property (p_len) else $error("operand length wrong");
   property p_mask_set;
      take && OPCODE_I == 8'h01 |-> ##2 DONE_O && IRQ_MASK_O == 2'h3;
   endproperty
   a_mask_set: assert property (p_mask_set) else $error("mask not raised");
   property p_mask_clr;
      take && OPCODE_I == 8'h02 |-> ##2 DONE_O && IRQ_MASK_O == 2'h0;
   endproperty
   a_mask_clr: assert property (p_mask_clr) else $error("mask not lowered");
   property p_halt;
      take && OPCODE_I == 8'h04 |-> ##2 DONE_O ##[0:1] HALT_O;
   endproperty
   a_halt: assert property (p_halt) else $error("halt not entered");
   property p_idx0;
      take && OPCODE_I[7:3] == 5'h04 && !OPCODE_I[2]
         |-> ##2 DONE_O && EA_O == 16'($past(X_I, 2));
   endproperty
   a_idx0: assert property (p_idx0) else $error("no-offset address wrong");
   property p_rmw_long;
      take && OPCODE_I[7:3] == 5'h03 && OPCODE_I[0] |-> ##2 DONE_O && ILLEGAL_O && !RMW_O;
   endproperty
   a_rmw_long: assert property (p_rmw_long) else $error("long rmw accepted");
   property p_sidx;
      DONE_O && MODE_O == AMD_M_SIDX |-> EA_O[15:9] == 7'h00;
   endproperty
   a_sidx: assert property (p_sidx) else $error("short indexed too wide");
   property p_ptr;
      PTR_RD_O |-> PTR_ADDR_O[15:8] == 8'h00 ##1 !PTR_RD_O;
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer read off page zero");
endmodule
bind amd_decoder amd_decoder_checker #(.IDX_W(IDX_W)) i_chk (
   .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .OP_VALID_I(OP_VALID_I), .OPCODE_I(OPCODE_I),
   .X_I(X_I), .BUSY_O(BUSY_O), .WAIT_O(WAIT_O), .HALT_O(HALT_O), .PTR_RD_O(PTR_RD_O),
   .PTR_ADDR_O(PTR_ADDR_O), .DONE_O(DONE_O), .MODE_O(MODE_O), .LEN_O(LEN_O),
   .EA_O(EA_O), .ILLEGAL_O(ILLEGAL_O), .RMW_O(RMW_O), .IRQ_MASK_O(IRQ_MASK_O));

// *** tb/amd_mem_model.sv ***
// page-zero pointer memory answering the decoder's pointer reads
// assumes single-cycle read pulses and at most one read outstanding
`timescale 1ns/10ps
module amd_mem_model (
   input logic clk_i,
   input logic rd_i,
   input logic [15:0] addr_i,
   output logic valid_o,
   output logic [7:0] data_o
);
   bit pend = 1'b0;
   int wait_n = 0;
   logic [7:0] adr = 8'h00;
   initial begin
      valid_o = 1'b0;
      data_o = 8'h00;
   end
   // idle data flips every cycle so a stale byte never passes as an answer
   always @(posedge clk_i) begin
      valid_o <= 1'b0;
      data_o <= ~data_o;
      if (rd_i) begin
         pend = 1'b1;
         wait_n = $urandom_range(2, 0);
         adr = addr_i[7:0];
      end
      if (pend) begin
         if (wait_n == 0) begin
            valid_o <= 1'b1;
            data_o <= {adr[3:0], adr[7:4]} ^ 8'h3c;
            pend = 1'b0;
         end else begin
            wait_n--;
         end
      end
   end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the addressing-mode decoder with a pointer memory
// assumes the opcode layout and timing of the decoder hand-over
`timescale 1ns/10ps
module tb_top;
   import amd_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0, op_valid = 1'b0, byte_valid = 1'b0, irq = 1'b0;
   logic [7:0] opcode = 8'h00, byte_d = 8'h00, x = 8'h00, y = 8'h00, ptr_data, imm;
   logic [15:0] pc = 16'h0000, ptr_addr, ea, target;
   logic ptr_valid, busy, byte_ready, ptr_rd, done, rmw, ill, wait_s, halt_s;
   logic [2:0] len;
   logic [1:0] mask, mask_exp;
   amd_mode_t mode;
   int err_count = 0, checks = 0;
   bit [16:0] short_m = 17'h1e2b4;
   int nbytes[17] = '{0, 1, 1, 2, 0, 1, 2, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2};
   int lenadd[17] = '{0, 1, 1, 2, 0, 1, 2, 2, 2, 2, 2, 1, 2, 1, 2, 2, 3};
   always #12.5 clock = ~clock;
   amd_decoder #(.IDX_W(8)) i_dut (
      .CLOCK_I(clock), .RST_N_I(rst_n), .OP_VALID_I(op_valid), .OPCODE_I(opcode),
      .PC_I(pc), .X_I(x), .Y_I(y), .BYTE_VALID_I(byte_valid), .BYTE_I(byte_d),
      .PTR_VALID_I(ptr_valid), .PTR_DATA_I(ptr_data), .IRQ_I(irq), .BUSY_O(busy),
      .BYTE_READY_O(byte_ready), .PTR_RD_O(ptr_rd), .PTR_ADDR_O(ptr_addr), .DONE_O(done),
      .MODE_O(mode), .LEN_O(len), .EA_O(ea), .TARGET_O(target), .IMM_O(imm), .RMW_O(rmw),
      .ILLEGAL_O(ill), .IRQ_MASK_O(mask), .WAIT_O(wait_s), .HALT_O(halt_s));
   amd_mem_model i_mem (.clk_i(clock), .rd_i(ptr_rd), .addr_i(ptr_addr),
      .valid_o(ptr_valid), .data_o(ptr_data));
   function automatic logic [7:0] pat(input logic [7:0] a);
      return {a[3:0], a[7:4]} ^ 8'h3c;
   endfunction
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic do_reset(input int n);
      rst_n <= 1'b0;
      op_valid <= 1'b0;
      byte_valid <= 1'b0;
      repeat (n) @(posedge clock);
      chk("busy", 16'h0, busy);
      chk("mask", 16'h3, mask);
      chk("len", 16'h1, len);
      chk("mode", 16'h0, mode);
      rst_n <= 1'b1;
      mask_exp = 2'h3;
   endtask
   task automatic run(input logic [7:0] op);
      logic [7:0] b[3], xv, yv, ofs;
      logic [15:0] pcv, idx, pw, e, t;
      int m, n, k, nb;
      bit bad, fin;
      m = op[7:3];
      b[0] = $urandom;
      b[1] = $urandom;
      xv = $urandom;
      yv = $urandom;
      pcv = $urandom;
      bad = m > 16 || (op[0] && m != 0 && !short_m[m]);
      nb = bad ? 0 : nbytes[m];
      idx = {8'h00, op[2] ? yv : xv};
      pw = {pat(b[0]), pat(b[0] + 8'h01)};
      case (m)
         2, 13, 15: e = {8'h00, b[0]};
         3: e = {b[0], b[1]};
         4: e = idx;
         5: e = idx + b[0];
         6: e = {b[0], b[1]} + idx;
         7, 14, 16: e = {8'h00, pat(b[0])};
         8: e = pw;
         9: e = idx + pat(b[0]);
         10: e = pw + idx;
         default: e = 16'h0000;
      endcase
      if (bad) e = 16'h0000;
      ofs = (m >= 15) ? b[1] : ((m == 12) ? pat(b[0]) : b[0]);
      t = (!bad && (m == 11 || m == 12 || m == 15 || m == 16)) ? pcv + {{8{ofs[7]}}, ofs} : pcv;
      op_valid <= 1'b1;
      opcode <= op;
      x <= xv;
      y <= yv;
      pc <= pcv;
      @(posedge clock);
      // held one more edge while busy: must be ignored
      opcode <= ~op;
      n = 0;
      fin = 1'b0;
      @(posedge clock);
      op_valid <= 1'b0;
      repeat (40) begin
         @(posedge clock);
         if (byte_ready && byte_valid) n++;
         if (done) begin
            fin = 1'b1;
            break;
         end
         k = ($urandom % 4 != 0) && n < nb;
         byte_valid <= k;
         byte_d <= k ? b[n] : ~byte_d;
      end
      byte_valid <= 1'b0;
      chk("done", 16'h1, fin);
      chk("illegal", bad, ill);
      chk("mode", bad ? 0 : m, mode);
      chk("bytes", nb, n);
      chk("ea", e, ea);
      chk("imm", (m == 1 && !bad) ? b[0] : 0, imm);
      chk("rmw", op[0] && m != 0 && !bad, rmw);
      chk("len", bad ? 1 : 1 + lenadd[m], len);
      chk("target", t, target);
      if (!bad && m == 0 && op[2:0] == 3'h1) mask_exp = 2'h3;
      if (!bad && m == 0 && op[2:0] == 3'h2) mask_exp = 2'h0;
      if (!bad && m == 0 && (op[2:0] == 3'h3 || op[2:0] == 3'h4)) begin
         @(posedge clock);
         chk("wait", op[2:0] == 3'h3, wait_s);
         chk("halt", op[2:0] == 3'h4, halt_s);
         op_valid <= 1'b1;
         opcode <= 8'h02;
         repeat (3) @(posedge clock);
         op_valid <= 1'b0;
         irq <= 1'b1;
         repeat (10) begin
            @(posedge clock);
            if (!wait_s && !halt_s) break;
         end
         irq <= 1'b0;
         chk("asleep", 16'h0, wait_s | halt_s);
      end
      chk("mask", mask_exp, mask);
      $display("test opcode %h done", op);
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      $display("ERROR watchdog expected finish seen hang");
      end_of_test;
   end
   initial begin
      logic [7:0] ops[10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h00, 8'h19, 8'h20, 8'h29,
         8'h41, 8'h01};
      void'($urandom(72));
      do_reset(6);
      foreach (ops[i]) run(ops[i]);
      for (int r = 0; r < 3; r++) begin
         for (int m = 0; m < 32; m++) run({m[4:0], 3'($urandom)});
      end
      // reset in mid pointer fetch; the late answer must be ignored
      op_valid <= 1'b1;
      opcode <= 8'h40;
      @(posedge clock);
      op_valid <= 1'b0;
      byte_valid <= 1'b1;
      byte_d <= $urandom;
      @(posedge clock);
      byte_valid <= 1'b0;
      repeat (2) @(posedge clock);
      do_reset(2);
      run(8'h40);
      end_of_test;
   end
endmodule

// *** verilog/amd_decoder.sv ***
// operand addressing-mode decoder: takes an opcode, collects its extension
// bytes, fetches page-zero pointers and issues the effective address
// assumes a fetch unit feeding bytes in order and a memory port answering
// one pointer read at a time; inputs are synchronous to CLOCK_I
//
// Functional notes
// - seventeen addressing modes in seven families
// - short variants address page zero 0000-00ff, short indexed forms reach 0000-01fe
// - read-modify-write only with short variants
// - inherent instructions are one byte
// - immediate is opcode plus one operand byte
// - short direct uses one address byte
// - long direct uses two-byte address
// - indexed adds X or Y unsigned
// - no-offset indexed uses index directly
// - short indexed adds one-byte offset, to 1fe
// - long indexed adds two-byte offset
// - short indirect reads byte pointer from page zero
// - long indirect reads word pointer from page zero
// - mask-set op raises mask to level 3
// - mask-clear op lowers mask to level 0
// - halt stops oscillator; wait sleeps until interrupt
// - long variants reach full 64 kbyte space
`timescale 1ns/10ps
`include "amd_map.svh"

module amd_decoder #(
   parameter int IDX_W = 8
) (
   input logic CLOCK_I,
   input logic RST_N_I,
   input logic OP_VALID_I,
   input logic [7:0] OPCODE_I,
   input logic [15:0] PC_I,
   input logic [IDX_W-1:0] X_I,
   input logic [IDX_W-1:0] Y_I,
   input logic BYTE_VALID_I,
   input logic [7:0] BYTE_I,
   input logic PTR_VALID_I,
   input logic [7:0] PTR_DATA_I,
   input logic IRQ_I,
   output logic BUSY_O,
   output logic BYTE_READY_O,
   output logic PTR_RD_O,
   output logic [15:0] PTR_ADDR_O,
   output logic DONE_O,
   output amd_pkg::amd_mode_t MODE_O,
   output logic [2:0] LEN_O,
   output logic [15:0] EA_O,
   output logic [15:0] TARGET_O,
   output logic [7:0] IMM_O,
   output logic RMW_O,
   output logic ILLEGAL_O,
   output logic [1:0] IRQ_MASK_O,
   output logic WAIT_O,
   output logic HALT_O
);
   import amd_pkg::*;

   if (IDX_W < 1 || IDX_W > 8) begin : g_bad_idx
      $error("amd_decoder: index width must be 1 to 8");
   end

   // bytes that follow the opcode
   function automatic logic [1:0] ext_of(input amd_mode_t m);
      unique case (m)
         AMD_M_INH, AMD_M_IDX0: ext_of = `AMD_NO_BYTES;
         AMD_M_LDIR, AMD_M_LIDX, AMD_M_BITDR, AMD_M_BITIR: ext_of = `AMD_TWO_BYTES;
         default: ext_of = `AMD_ONE_BYTE;
      endcase
   endfunction

   // pointer bytes read from page zero
   function automatic logic [1:0] ptr_of(input amd_mode_t m);
      unique case (m)
         AMD_M_SIND, AMD_M_SII, AMD_M_RELI, AMD_M_BITI, AMD_M_BITIR:
            ptr_of = `AMD_ONE_BYTE;
         AMD_M_LIND, AMD_M_LII: ptr_of = `AMD_TWO_BYTES;
         default: ptr_of = `AMD_NO_BYTES;
      endcase
   endfunction

   // length added to the opcode; indirect forms count their prefix byte
   function automatic logic [1:0] len_of(input amd_mode_t m);
      unique case (m)
         AMD_M_INH, AMD_M_IDX0: len_of = `AMD_NO_BYTES;
         AMD_M_IMM, AMD_M_SDIR, AMD_M_SIDX, AMD_M_RELD, AMD_M_BITD: len_of = `AMD_ONE_BYTE;
         AMD_M_BITIR: len_of = `AMD_THREE_BYTES;
         default: len_of = `AMD_TWO_BYTES;
      endcase
   endfunction

   // read-modify-write operations exist only in short forms
   function automatic logic rmw_ok(input amd_mode_t m);
      unique case (m)
         AMD_M_SDIR, AMD_M_IDX0, AMD_M_SIDX, AMD_M_SIND, AMD_M_SII,
         AMD_M_BITD, AMD_M_BITI, AMD_M_BITDR, AMD_M_BITIR: rmw_ok = 1'b1;
         default: rmw_ok = 1'b0;
      endcase
   endfunction

   amd_state_t state_r;
   amd_state_t state_nxt;
   amd_mode_t mode_r;
   logic [4:0] dec_code;
   amd_mode_t dec_mode;
   logic dec_rmw;
   logic dec_bad;
   logic take;
   logic last_byte;
   logic last_ptr;
   logic [2:0] op_r;
   logic rmw_r;
   logic bad_r;
   logic [1:0] ext_r;
   logic [1:0] ptrn_r;
   logic [1:0] cnt_r;
   logic [1:0] pcnt_r;
   logic [7:0] b0_r;
   logic [7:0] b1_r;
   logic [7:0] ptr_hi_r;
   logic [7:0] ptr_lo_r;
   logic [IDX_W-1:0] idx_r;
   logic [15:0] pc_r;
   logic [15:0] ea_w;
   logic [15:0] target_w;
   logic busy_r;
   logic byte_rdy_r;
   logic ptr_rd_r;
   logic [15:0] ptr_addr_r;
   logic done_r;
   amd_mode_t mode_out_r;
   logic [2:0] len_r;
   logic [15:0] ea_r;
   logic [15:0] target_r;
   logic [7:0] imm_r;
   logic rmw_out_r;
   logic illegal_r;
   logic [1:0] mask_r;
   logic wait_r;
   logic halt_r;
   logic issue_ctl;

   assign dec_code = OPCODE_I[`AMD_OPC_MODE_HI:`AMD_OPC_MODE_LO];
   assign dec_mode = amd_mode_t'(dec_code);
   assign dec_rmw = (dec_mode != AMD_M_INH) && OPCODE_I[`AMD_OPC_RMW];
   // codes past the seventeenth mode and long read-modify-write are refused
   assign dec_bad = (dec_code >= `AMD_MODE_COUNT) || (dec_rmw && !rmw_ok(dec_mode));
   // no new opcode while asleep: the core is stopped
   assign take = OP_VALID_I && !wait_r && !halt_r;
   assign last_byte = (2'(cnt_r + `AMD_ONE_BYTE) == ext_r);
   assign last_ptr = (2'(pcnt_r + `AMD_ONE_BYTE) == ptrn_r);
   assign issue_ctl = (state_r == AMD_S_ISSUE) && !bad_r && (mode_r == AMD_M_INH);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         AMD_S_IDLE: begin
            if (take) begin
               if (dec_bad || ext_of(dec_mode) == `AMD_NO_BYTES) begin
                  state_nxt = AMD_S_ISSUE;
               end else begin
                  state_nxt = AMD_S_COLLECT;
               end
            end
         end
         AMD_S_COLLECT: begin
            if (BYTE_VALID_I && last_byte) begin
               state_nxt = (ptrn_r != `AMD_NO_BYTES) ? AMD_S_POINTER : AMD_S_ISSUE;
            end
         end
         AMD_S_POINTER: begin
            if (PTR_VALID_I && last_ptr) begin
               state_nxt = AMD_S_ISSUE;
            end
         end
         AMD_S_ISSUE: state_nxt = AMD_S_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         state_r <= AMD_S_IDLE;
         busy_r <= 1'b0;
         byte_rdy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         busy_r <= (state_nxt != AMD_S_IDLE);
         byte_rdy_r <= (state_nxt == AMD_S_COLLECT);
      end
   end

   // opcode capture
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         mode_r <= AMD_M_INH;
         op_r <= 3'h0;
         rmw_r <= 1'b0;
         bad_r <= 1'b0;
         ext_r <= `AMD_NO_BYTES;
         ptrn_r <= `AMD_NO_BYTES;
         idx_r <= '0;
         pc_r <= `AMD_ADDR_ZERO;
      end else if (state_r == AMD_S_IDLE && take) begin
         mode_r <= dec_bad ? AMD_M_INH : dec_mode;
         op_r <= OPCODE_I[`AMD_OPC_OP_HI:`AMD_OPC_OP_LO];
         rmw_r <= dec_rmw;
         bad_r <= dec_bad;
         ext_r <= ext_of(dec_mode);
         ptrn_r <= ptr_of(dec_mode);
         idx_r <= OPCODE_I[`AMD_OPC_YSEL] ? Y_I : X_I;
         pc_r <= PC_I;
      end
   end

   // extension bytes, first byte is the high byte of a word
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         cnt_r <= `AMD_NO_BYTES;
         b0_r <= `AMD_BYTE_ZERO;
         b1_r <= `AMD_BYTE_ZERO;
      end else if (state_r == AMD_S_IDLE) begin
         cnt_r <= `AMD_NO_BYTES;
         b0_r <= `AMD_BYTE_ZERO;
         b1_r <= `AMD_BYTE_ZERO;
      end else if (state_r == AMD_S_COLLECT && BYTE_VALID_I) begin
         cnt_r <= 2'(cnt_r + `AMD_ONE_BYTE);
         if (cnt_r == `AMD_NO_BYTES) begin
            b0_r <= BYTE_I;
         end else begin
            b1_r <= BYTE_I;
         end
      end
   end

   // pointer fetch; bytes shift in high first and the address wraps in page zero
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         pcnt_r <= `AMD_NO_BYTES;
         ptr_hi_r <= `AMD_BYTE_ZERO;
         ptr_lo_r <= `AMD_BYTE_ZERO;
         ptr_rd_r <= 1'b0;
         ptr_addr_r <= `AMD_ADDR_ZERO;
      end else begin
         ptr_rd_r <= 1'b0;
         if (state_r == AMD_S_IDLE) begin
            pcnt_r <= `AMD_NO_BYTES;
            ptr_hi_r <= `AMD_BYTE_ZERO;
            ptr_lo_r <= `AMD_BYTE_ZERO;
         end else if (state_r == AMD_S_COLLECT && state_nxt == AMD_S_POINTER) begin
            ptr_rd_r <= 1'b1;
            ptr_addr_r <= {`AMD_PAGE_ZERO_HI, ((cnt_r == `AMD_NO_BYTES) ? BYTE_I : b0_r)};
         end else if (state_r == AMD_S_POINTER && PTR_VALID_I) begin
            ptr_hi_r <= ptr_lo_r;
            ptr_lo_r <= PTR_DATA_I;
            if (!last_ptr) begin
               pcnt_r <= 2'(pcnt_r + `AMD_ONE_BYTE);
               ptr_rd_r <= 1'b1;
               ptr_addr_r <= {`AMD_PAGE_ZERO_HI, 8'(b0_r + 8'h01)};
            end
         end
      end
   end

   amd_ea_adder #(
      .IDX_W(IDX_W)
   ) u_adder (
      .mode_i(mode_r),
      .b0_i(b0_r),
      .b1_i(b1_r),
      .ptr_hi_i(ptr_hi_r),
      .ptr_lo_i(ptr_lo_r),
      .idx_i(idx_r),
      .pc_i(pc_r),
      .ea_o(ea_w),
      .target_o(target_w)
   );

   // result, held until the next issue, except done, which pulses for one cycle
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         done_r <= 1'b0;
         mode_out_r <= AMD_M_INH;
         len_r <= `AMD_OPCODE_LEN;
         ea_r <= `AMD_ADDR_ZERO;
         target_r <= `AMD_ADDR_ZERO;
         imm_r <= `AMD_BYTE_ZERO;
         rmw_out_r <= 1'b0;
         illegal_r <= 1'b0;
      end else begin
         done_r <= (state_r == AMD_S_ISSUE);
         if (state_r == AMD_S_ISSUE) begin
            mode_out_r <= mode_r;
            len_r <= bad_r ? `AMD_OPCODE_LEN : 3'(`AMD_OPCODE_LEN + 3'(len_of(mode_r)));
            ea_r <= bad_r ? `AMD_ADDR_ZERO : ea_w;
            target_r <= target_w;
            imm_r <= (mode_r == AMD_M_IMM) ? b0_r : `AMD_BYTE_ZERO;
            rmw_out_r <= rmw_r && !bad_r;
            illegal_r <= bad_r;
         end
      end
   end

   // interrupt mask level
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         mask_r <= `AMD_MASK_RESET;
      end else if (issue_ctl && op_r == `AMD_INH_SET_MASK) begin
         mask_r <= `AMD_MASK_SET;
      end else if (issue_ctl && op_r == `AMD_INH_CLR_MASK) begin
         mask_r <= `AMD_MASK_CLEAR;
      end
   end

   // low power: entry wins over a wake interrupt in the same cycle
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         wait_r <= 1'b0;
         halt_r <= 1'b0;
      end else begin
         if (issue_ctl && op_r == `AMD_INH_WAIT) begin
            wait_r <= 1'b1;
         end else if (IRQ_I) begin
            wait_r <= 1'b0;
         end
         if (issue_ctl && op_r == `AMD_INH_HALT) begin
            halt_r <= 1'b1;
         end else if (IRQ_I) begin
            halt_r <= 1'b0;
         end
      end
   end

   assign BUSY_O = busy_r;
   assign BYTE_READY_O = byte_rdy_r;
   assign PTR_RD_O = ptr_rd_r;
   assign PTR_ADDR_O = ptr_addr_r;
   assign DONE_O = done_r;
   assign MODE_O = mode_out_r;
   assign LEN_O = len_r;
   assign EA_O = ea_r;
   assign TARGET_O = target_r;
   assign IMM_O = imm_r;
   assign RMW_O = rmw_out_r;
   assign ILLEGAL_O = illegal_r;
   assign IRQ_MASK_O = mask_r;
   assign WAIT_O = wait_r;
   assign HALT_O = halt_r;

endmodule

// *** verilog/amd_ea_adder.sv ***
// effective address and branch target former for the addressing-mode decoder
// assumes operand bytes, pointer bytes, index and pc are stable while it is read
`timescale 1ns/10ps
`include "amd_map.svh"

module amd_ea_adder #(
   parameter int IDX_W = 8
) (
   input amd_pkg::amd_mode_t mode_i,
   input logic [7:0] b0_i,
   input logic [7:0] b1_i,
   input logic [7:0] ptr_hi_i,
   input logic [7:0] ptr_lo_i,
   input logic [IDX_W-1:0] idx_i,
   input logic [15:0] pc_i,
   output logic [15:0] ea_o,
   output logic [15:0] target_o
);
   import amd_pkg::*;

   if (IDX_W < 1 || IDX_W > 8) begin : g_bad_idx
      $error("amd_ea_adder: index width must be 1 to 8");
   end

   logic [15:0] idx16;
   logic [15:0] short_sum;

   // zero-extended index, unsigned add
   assign idx16 = {{(16-IDX_W){1'b0}}, idx_i};

   always_comb begin
      ea_o = `AMD_ADDR_ZERO;
      target_o = pc_i;
      short_sum = `AMD_ADDR_ZERO;
      unique case (mode_i)
         AMD_M_SDIR, AMD_M_BITD: ea_o = {`AMD_PAGE_ZERO_HI, b0_i};
         AMD_M_LDIR: ea_o = {b0_i, b1_i};
         AMD_M_IDX0: ea_o = idx16;
         AMD_M_SIDX: begin
            // 16-bit sum keeps the byte carry, so reach is 000 to 1fe
            short_sum = {`AMD_PAGE_ZERO_HI, b0_i} + idx16;
            ea_o = short_sum;
         end
         AMD_M_LIDX: ea_o = {b0_i, b1_i} + idx16;
         AMD_M_SIND, AMD_M_BITI: ea_o = {`AMD_PAGE_ZERO_HI, ptr_lo_i};
         AMD_M_LIND: ea_o = {ptr_hi_i, ptr_lo_i};
         AMD_M_SII: begin
            short_sum = {`AMD_PAGE_ZERO_HI, ptr_lo_i} + idx16;
            ea_o = short_sum;
         end
         AMD_M_LII: ea_o = {ptr_hi_i, ptr_lo_i} + idx16;
         AMD_M_RELD: target_o = pc_i + {{8{b0_i[7]}}, b0_i};
         AMD_M_RELI: target_o = pc_i + {{8{ptr_lo_i[7]}}, ptr_lo_i};
         AMD_M_BITDR: begin
            ea_o = {`AMD_PAGE_ZERO_HI, b0_i};
            target_o = pc_i + {{8{b1_i[7]}}, b1_i};
         end
         AMD_M_BITIR: begin
            ea_o = {`AMD_PAGE_ZERO_HI, ptr_lo_i};
            target_o = pc_i + {{8{b1_i[7]}}, b1_i};
         end
         default: ea_o = `AMD_ADDR_ZERO;
      endcase
   end

endmodule

// *** verilog/amd_map.svh ***
// named numbers of the addressing-mode decoder: opcode fields, counts, levels
// assumes nothing; included by the decoder and its address adder
`ifndef AMD_MAP_SVH
`define AMD_MAP_SVH

// opcode layout: [7:3] addressing mode, [2:0] operation / index select
`define AMD_OPC_MODE_HI 7
`define AMD_OPC_MODE_LO 3
`define AMD_OPC_YSEL 2
`define AMD_OPC_RMW 0
`define AMD_OPC_OP_HI 2
`define AMD_OPC_OP_LO 0
`define AMD_MODE_COUNT 5'h11

// inherent operation codes in opcode[2:0]
`define AMD_INH_SET_MASK 3'h1
`define AMD_INH_CLR_MASK 3'h2
`define AMD_INH_WAIT 3'h3
`define AMD_INH_HALT 3'h4

// interrupt mask levels
`define AMD_MASK_SET 2'h3
`define AMD_MASK_CLEAR 2'h0
`define AMD_MASK_RESET 2'h3

// byte counts
`define AMD_NO_BYTES 2'h0
`define AMD_ONE_BYTE 2'h1
`define AMD_TWO_BYTES 2'h2
`define AMD_THREE_BYTES 2'h3
`define AMD_OPCODE_LEN 3'h1

`define AMD_PAGE_ZERO_HI 8'h00
`define AMD_BYTE_ZERO 8'h00
`define AMD_ADDR_ZERO 16'h0000

`endif

// *** verilog/amd_pkg.sv ***
// types of the addressing-mode decoder: mode codes and sequencer states
// assumes the opcode field layout in amd_map.svh
package amd_pkg;

   typedef enum logic [4:0] {
      AMD_M_INH   = 5'h00,
      AMD_M_IMM   = 5'h01,
      AMD_M_SDIR  = 5'h02,
      AMD_M_LDIR  = 5'h03,
      AMD_M_IDX0  = 5'h04,
      AMD_M_SIDX  = 5'h05,
      AMD_M_LIDX  = 5'h06,
      AMD_M_SIND  = 5'h07,
      AMD_M_LIND  = 5'h08,
      AMD_M_SII   = 5'h09,
      AMD_M_LII   = 5'h0a,
      AMD_M_RELD  = 5'h0b,
      AMD_M_RELI  = 5'h0c,
      AMD_M_BITD  = 5'h0d,
      AMD_M_BITI  = 5'h0e,
      AMD_M_BITDR = 5'h0f,
      AMD_M_BITIR = 5'h10
   } amd_mode_t;

   typedef enum logic [1:0] {
      AMD_S_IDLE    = 2'b00,
      AMD_S_COLLECT = 2'b01,
      AMD_S_POINTER = 2'b11,
      AMD_S_ISSUE   = 2'b10
   } amd_state_t;

endpackage
